// ===== core/ovr_ctrl.sv
// Muting override control: override pulse check, release during
// override, cycle count limit, request pulsing, and APB registers.
// Assumes field inputs synchronous to pclk, from the muting block.
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ns

// Overview of operation
// - accept override pulse only within width limits
// - release high while override cycle runs
// - limit cycles to sixty minutes over time
// - five and ten seconds give ceiling 360
// - fifteen minutes up or inactive give five
// - count up when request starts pulsing
// - clear count after the first valid muting since reset or restart
// - valid override while requesting restarts release
// - sensor fault abort: request for one cycle
// - faulty sensor high then low rearms
// - suspend direction, sequence, simultaneity checks
// - pulse request only under four conditions
// - end override when sensors low, field clear
module ovr_ctrl
	import ovr_pkg::*;
#(
	parameter int unsigned TICK_DIV = TICK_CYC  // pclk cycles per ms tick
)(
	input  wire logic           pclk,
	input  wire logic           presetn,
	input  wire logic           psel,
	input  wire logic           penable,
	input  wire logic           pwrite,
	input  wire logic [7:0]     paddr,
	input  wire logic [31:0]    pwdata,
	output logic [31:0]         prdata,
	output logic                pready,
	output logic                pslverr,
	input  wire logic           override_in,
	input  wire ovr_pkg::field_s field_in,
	output ovr_pkg::ctl_s        ctl_out,
	output logic                irq
);
	// Override cycle states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_REQ  = 3'b010,
		ST_OVR  = 3'b100
	} ovr_e;

	ovr_e         st_q;         // Override state
	ovr_e         st_d;         // Next state
	logic [31:0]  ctrl_q;       // Control register
	logic [EV_W-1:0] ev_q;      // Sticky events
	logic [EV_W-1:0] mask_q;    // Interrupt mask
	logic [8:0]   cnt_q;        // Override cycles used
	logic [11:0]  width_q;      // Override high time in ms
	logic         ovr_in_q;     // Override input last cycle
	logic [7:0]   blink_q;      // Request half-period counter, ms
	logic         phase_q;      // Request pulse phase
	logic         fault_q;      // Sensor fault, waiting rearm
	logic         fault_hi_q;   // Faulty sensor returned high
	logic         clr_arm_q;    // Count clear armed by a restart
	logic         req_q;        // Request output
	logic         rel_q;        // Release output
	logic         prdy_q;       // APB ready
	logic         perr_q;       // APB error
	logic [31:0]  rdata_q;      // APB read data
	logic         irq_q;        // Interrupt output

	wire          tick;         // Millisecond tick
	wire  [8:0]   limit;        // Permitted cycles

	// Millisecond prescaler
	ovr_tick #(
		.DIV     (TICK_DIV)
	) u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.tick    (tick)
	);

	// Permitted override cycle lookup
	ovr_limit u_limit (
		.tmt_sel (ctrl_q[CTRL_TIME_LSB +: CTRL_TIME_W]),
		.tmon_on (ctrl_q[CTRL_TMON_B]),
		.limit   (limit)
	);

	// Request conditions of the field
	wire any_sensor = |field_in.sensor;
	wire cond_ok    = !field_in.muting_status && any_sensor
		&& !field_in.safety_switch_output && !rel_q;
	wire at_limit   = (cnt_q >= limit);
	// Fault gate: requests held off until faulty sensor rearms
	wire fault_hold = fault_q;
	wire req_start  = (st_q == ST_IDLE) && cond_ok && !fault_hold
		&& !at_limit;
	// Falling edge of override input, width checked in ms
	wire ovr_fall   = ovr_in_q && !override_in;
	wire [11:0] min_ms = ctrl_q[CTRL_LONG_B] ? 12'(MIN_LONG_MS)
		: 12'(MIN_SHORT_MS);
	wire width_ok   = (width_q >= min_ms)
		&& (width_q <= 12'(MAX_PULSE_MS));
	wire ovr_valid  = ovr_fall && width_ok;
	// Field clear ends an override cycle
	wire field_clear = !any_sensor && field_in.safety_switch_output;
	// One-cycle request on sensor fault abort
	wire fault_req  = field_in.sensor_fault && cond_ok;

	// APB decode
	wire acc   = psel && penable && !prdy_q;
	// Writes land at the completing edge, where pready is high
	wire wr    = psel && penable && prdy_q && pwrite;
	wire known = (paddr == CTRL_OFF) || (paddr == STAT_OFF)
		|| (paddr == IRQ_OFF) || (paddr == MASK_OFF)
		|| (paddr == CNT_OFF);
	wire wr_ctrl = wr && (paddr == CTRL_OFF);
	wire wr_irq  = wr && (paddr == IRQ_OFF);
	wire wr_mask = wr && (paddr == MASK_OFF);
	wire [31:0] stat_word = {25'h0, at_limit, fault_q, rel_q, req_q,
		st_q == ST_OVR, st_q == ST_REQ, st_q == ST_IDLE};
	wire [31:0] rd_mux = (paddr == CTRL_OFF) ? ctrl_q
		: (paddr == STAT_OFF) ? stat_word
		: (paddr == IRQ_OFF)  ? {29'h0, ev_q}
		: (paddr == MASK_OFF) ? {29'h0, mask_q}
		: (paddr == CNT_OFF)  ? {23'h00_0000, cnt_q}
		: 32'h0000_0000;

	// Events raised this cycle
	wire [EV_W-1:0] ev_set;
	assign ev_set[EV_REQ_B] = req_start;
	assign ev_set[EV_OVR_B] = (st_q == ST_REQ) && ovr_valid;
	assign ev_set[EV_LIM_B] = (st_q == ST_IDLE) && cond_ok && at_limit
		&& !fault_hold;

	// Next override state
	always_comb
	begin
		st_d = st_q;
		unique case (st_q)
			ST_IDLE:
				if (req_start)
					st_d = ST_REQ;
			ST_REQ:
				if (ovr_valid)
					st_d = ST_OVR;
				else if (!cond_ok)
					st_d = ST_IDLE;
			ST_OVR:
				if (field_clear)
					st_d = ST_IDLE;
		endcase
	end

	// Override state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_q <= ST_IDLE;
		else
			st_q <= st_d;
	end

	// Clear arm: set by reset or stop-to-run, spent by a valid muting.
	// Later muting cycles in run keep the count, so the limit holds.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			clr_arm_q <= 1'b1;
		else if (field_in.stop_to_run)
			clr_arm_q <= 1'b1;
		else if (field_in.valid_mute_done)
			clr_arm_q <= 1'b0;
	end

	// Cycle counter; clear after valid muting wins over the count
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_q <= 9'h000;
		else if (field_in.valid_mute_done && clr_arm_q)
			cnt_q <= 9'h000;
		else if (req_start)
			cnt_q <= cnt_q + 9'h001;
	end

	// Override high-time measure, saturating past the limit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			width_q  <= 12'h000;
			ovr_in_q <= 1'b0;
		end
		else
		begin
			ovr_in_q <= override_in;
			if (!override_in)
				width_q <= 12'h000;
			else if (tick && width_q != 12'hFFF)
				width_q <= width_q + 12'h001;
		end
	end

	// Sensor fault tracking: rearm after sensor high then low
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fault_q    <= 1'b0;
			fault_hi_q <= 1'b0;
		end
		else if (field_in.sensor_fault)
		begin
			fault_q    <= 1'b1;
			fault_hi_q <= 1'b0;
		end
		else if (fault_q && any_sensor)
			fault_hi_q <= 1'b1;
		else if (fault_q && fault_hi_q)
		begin
			fault_q    <= 1'b0;
			fault_hi_q <= 1'b0;
		end
	end

	// 2 Hz request blinker, restarted at each request start
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			blink_q <= 8'h00;
			phase_q <= 1'b0;
		end
		else if (st_q != ST_REQ)
		begin
			blink_q <= 8'h00;
			phase_q <= 1'b1;
		end
		else if (tick)
		begin
			if (blink_q == 8'(REQ_HALF_MS - 1))
			begin
				blink_q <= 8'h00;
				phase_q <= !phase_q;
			end
			else
				blink_q <= blink_q + 8'h01;
		end
	end

	// Field outputs, registered
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			req_q   <= 1'b0;
			rel_q   <= 1'b0;
			ctl_out <= '0;
		end
		else
		begin
			req_q <= ((st_d == ST_REQ) && phase_q) || fault_req;
			rel_q <= (st_d == ST_OVR);
			ctl_out.release_out     <= (st_d == ST_OVR);
			ctl_out.override_req    <= ((st_d == ST_REQ) && phase_q)
				|| fault_req;
			ctl_out.checks_suspend  <= (st_d == ST_OVR);
			ctl_out.override_active <= (st_d == ST_OVR);
		end
	end

	// Control and mask registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= CTRL_RST;
			mask_q <= '0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_q <= pwdata & 32'h0000_00F3;
			if (wr_mask)
				mask_q <= pwdata[EV_W-1:0];
		end
	end

	// Sticky events: a new event wins over a write-one clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ev_q <= '0;
		else
			ev_q <= (ev_q & ~(wr_irq ? pwdata[EV_W-1:0] : '0)) | ev_set;
	end

	// APB answer: one wait state, error on unmapped address
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdy_q  <= 1'b0;
			perr_q  <= 1'b0;
			rdata_q <= 32'h0000_0000;
			irq_q   <= 1'b0;
		end
		else
		begin
			prdy_q  <= acc;
			perr_q  <= acc && !known;
			rdata_q <= (acc && !pwrite) ? rd_mux : 32'h0000_0000;
			irq_q   <= |(ev_q & mask_q);
		end
	end

	assign pready  = prdy_q;
	assign pslverr = perr_q;
	assign prdata  = rdata_q;
	assign irq     = irq_q;

endmodule : ovr_ctrl

// ===== core/ovr_limit.sv
// Lookup of the permitted override cycle count from total muting time.
// Purely combinational; assumes a registered selection at its input.
`timescale 1ns/1ns
module ovr_limit
	import ovr_pkg::*;
(
	input  wire logic [3:0] tmt_sel,
	input  wire logic       tmon_on,
	output logic [8:0]      limit
);
	wire [11:0] ratio;  // Sixty minutes over the muting time
	wire        short_t; // 5 s or 10 s
	wire        long_t;  // 15 min or longer

	assign ratio   = 12'(SEC_PER_HOUR / tmt_seconds(tmt_sel));
	assign short_t = (tmt_sel == TMT_5S) || (tmt_sel == TMT_10S);
	assign long_t  = (tmt_sel >= TMT_15M);
	// Unmonitored gives the floor first, then ceiling, floor, division
	assign limit = !tmon_on ? CYC_FLOOR
		: short_t ? CYC_CEIL
		: long_t ? CYC_FLOOR
		: ratio[8:0];
endmodule : ovr_limit

// ===== core/ovr_pkg.sv
// Package for the muting override control block: register map, field
// positions, timing constants and carrier structs.
// Assumes a 10 MHz pclk and a 32-bit APB register bus.
package ovr_pkg;

	// Clock rate and prescaled tick
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned TICK_US       = 1000;
	localparam int unsigned TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;

	// Pulse-width limits in milliseconds, counted in ms ticks
	localparam int unsigned MIN_SHORT_MS  = 100;
	localparam int unsigned MIN_LONG_MS   = 350;
	localparam int unsigned MAX_PULSE_MS  = 3000;
	// Override-request rate: 2 Hz, so half period 250 ms
	localparam int unsigned REQ_HZ        = 2;
	localparam int unsigned REQ_HALF_MS   = 1000 / (2 * REQ_HZ);

	// Override cycle limits
	localparam logic [8:0] CYC_CEIL       = 9'h168;
	localparam logic [8:0] CYC_FLOOR      = 9'h005;
	localparam int unsigned SEC_PER_HOUR  = 3600;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFF       = 8'h00;
	localparam logic [7:0] STAT_OFF       = 8'h04;
	localparam logic [7:0] IRQ_OFF        = 8'h08;
	localparam logic [7:0] MASK_OFF       = 8'h0C;
	localparam logic [7:0] CNT_OFF        = 8'h10;

	// Control fields
	localparam int unsigned CTRL_LONG_B   = 0;
	localparam int unsigned CTRL_TMON_B   = 1;
	localparam int unsigned CTRL_TIME_LSB = 4;
	localparam int unsigned CTRL_TIME_W   = 4;
	localparam logic [31:0] CTRL_RST      = 32'h0000_0000;

	// Event bits of the interrupt status and mask registers
	localparam int unsigned EV_REQ_B      = 0;
	localparam int unsigned EV_OVR_B      = 1;
	localparam int unsigned EV_LIM_B      = 2;
	localparam int unsigned EV_W          = 3;

	// Total muting time selections
	typedef enum logic [3:0] {
		TMT_5S  = 4'h0, TMT_10S = 4'h1, TMT_20S = 4'h2, TMT_30S = 4'h3,
		TMT_1M  = 4'h4, TMT_5M  = 4'h5, TMT_15M = 4'h6, TMT_30M = 4'h7,
		TMT_60M = 4'h8
	} tmt_e;

	// Field inputs from the muting block
	typedef struct packed {
		logic       muting_status;
		logic [3:0] sensor;
		logic       safety_switch_output;
		logic       sensor_fault;
		logic       valid_mute_done;
		logic       stop_to_run;
	} field_s;

	// Outputs towards the muting block
	typedef struct packed {
		logic release_out;
		logic override_req;
		logic checks_suspend;
		logic override_active;
	} ctl_s;

	// Seconds of a total muting time selection
	function automatic int unsigned tmt_seconds(input logic [3:0] sel);
		unique case (sel)
			TMT_5S:  return 5;
			TMT_10S: return 10;
			TMT_20S: return 20;
			TMT_30S: return 30;
			TMT_1M:  return 60;
			TMT_5M:  return 300;
			TMT_15M: return 900;
			TMT_30M: return 1800;
			default: return 3600;
		endcase
	endfunction : tmt_seconds

endpackage : ovr_pkg

// ===== core/ovr_tick.sv
// Prescaler giving a one-cycle tick every millisecond of pclk.
// Assumes pclk at the rate set in the package.
`timescale 1ns/1ns
module ovr_tick
	import ovr_pkg::*;
#(
	parameter int unsigned DIV = TICK_CYC
)(
	input  wire logic pclk,
	input  wire logic presetn,
	output logic      tick
);
	logic [15:0] cnt_q;  // Cycles into the current period

	// Free-running divider, tick on wrap
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q <= 16'h0000;
			tick  <= 1'b0;
		end
		else
		begin
			tick  <= (cnt_q == 16'(DIV - 1));
			cnt_q <= (cnt_q == 16'(DIV - 1)) ? 16'h0000 : cnt_q + 16'h0001;
		end
	end
endmodule : ovr_tick

// ===== dv/mute_field.sv
// Model of sensors, safety switch and override button.
// Assumes the bench calls its tasks; all changes follow a pclk edge.
`timescale 1ns/1ns
module mute_field
(
	input wire logic        pclk,
	output ovr_pkg::field_s field,
	output logic            override_in
);
	import ovr_pkg::*;
	// Quiet field, button released
	initial
	begin
		field = '0;
		override_in = 1'b0;
	end
	// Set muting status, sensors and safety output
	task automatic put(input logic ms, input logic [3:0] sn, input logic ss);
		@(posedge pclk);
		field.muting_status <= ms;
		field.sensor <= sn;
		field.safety_switch_output <= ss;
	endtask : put
	// One-cycle completed muting cycle
	task automatic mute_done();
		@(posedge pclk);
		field.valid_mute_done <= 1'b1;
		@(posedge pclk);
		field.valid_mute_done <= 1'b0;
	endtask : mute_done
	// Button held for n cycles
	task automatic press(input int n);
		@(posedge pclk);
		override_in <= 1'b1;
		repeat (n) @(posedge pclk);
		override_in <= 1'b0;
	endtask : press
	// One-cycle stop-to-run transition of the controller
	task automatic restart();
		@(posedge pclk);
		field.stop_to_run <= 1'b1;
		@(posedge pclk);
		field.stop_to_run <= 1'b0;
	endtask : restart
	// One-cycle sensor fault abort
	task automatic fault();
		@(posedge pclk);
		field.sensor_fault <= 1'b1;
		@(posedge pclk);
		field.sensor_fault <= 1'b0;
	endtask : fault
endmodule : mute_field

// ===== dv/ovr_ctrl_chk.sv
// Port checker for the muting override control block.
// Assumes it is bound onto ovr_ctrl and sees only its ports.
`timescale 1ns/1ns
module ovr_ctrl_chk
(
	input wire logic            pclk,
	input wire logic            presetn,
	input wire logic            psel,
	input wire logic            penable,
	input wire logic            pwrite,
	input wire logic [7:0]      paddr,
	input wire logic [31:0]     pwdata,
	input wire logic [31:0]     prdata,
	input wire logic            pready,
	input wire logic            pslverr,
	input wire logic            override_in,
	input wire ovr_pkg::field_s field_in,
	input wire ovr_pkg::ctl_s   ctl_out,
	input wire logic            irq
);
	import ovr_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Field state that allows a request
	wire cond = !field_in.muting_status && (|field_in.sensor)
		&& !field_in.safety_switch_output && !ctl_out.release_out;

	a_req_cond: assert property (
		$rose(ctl_out.override_req) |-> $past(cond))
		else $error("request rose without its conditions");
	a_ovr_suspend: assert property (
		ctl_out.override_active |-> ctl_out.checks_suspend)
		else $error("checks not suspended during override");
	a_ovr_release: assert property (
		ctl_out.override_active |-> ctl_out.release_out)
		else $error("release low during override");
	a_ovr_start: assert property (
		$rose(ctl_out.override_active)
		|-> $past(override_in, 2) && !$past(override_in))
		else $error("override began without a pulse end");
	a_ovr_end: assert property (
		$fell(ctl_out.override_active)
		|-> $past(field_in.sensor == 4'h0
		&& field_in.safety_switch_output))
		else $error("override ended with field not clear");
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_apb_answer: assert property (psel && penable && !pready |=> pready)
		else $error("no answer one cycle after access");
	a_prdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside answer cycle");
	a_slverr_ready: assert property (pslverr |-> pready)
		else $error("slave error without pready");
	c_req: cover property ($rose(ctl_out.override_req));
	c_err: cover property (pslverr);
	c_irq: cover property ($rose(irq));
	c_ovr: cover property ($rose(ctl_out.override_active));
endmodule : ovr_ctrl_chk

bind ovr_ctrl ovr_ctrl_chk ovr_ctrl_chk_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.override_in(override_in), .field_in(field_in), .ctl_out(ctl_out),
	.irq(irq));

// ===== dv/testbench.sv
// Self-checking bench for ovr_ctrl over APB and the field model.
// Assumes a 100 ns pclk and a 10-cycle ms tick to keep pulses short.
`timescale 1ns/1ns
module testbench;
	import ovr_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic        pready, pslverr, serr, irq, override_in;
	field_s      field;
	ctl_s        ctl;
	int          err_count = 0, cmp_count = 0, i, j;
	int          lim [10] = '{360, 360, 180, 120, 60, 12, 5, 5, 5, 5};
	localparam int MS = 10;  // Cycles per ms tick in this bench

	ovr_ctrl #(.TICK_DIV(MS)) ovr_ctrl_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .override_in(override_in), .field_in(field),
		.ctl_out(ctl), .irq(irq));
	mute_field mute_field_i (.pclk(pclk), .field(field),
		.override_in(override_in));

	// Free-running clock
	always #50 pclk = ~pclk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; waits for pready, the watchdog bounds the wait
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic results();
		$display("mismatches %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results

	// Watchdog well beyond the expected run
	initial
	begin
		repeat (90000) @(posedge pclk);
		err_count++;
		results();
	end

	// Main sequence
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, CTRL_OFF, 0);
		chk(rdat, CTRL_RST);
		apb(1'b0, CNT_OFF, 0);
		chk(rdat, 32'h0);
		apb(1'b0, 8'h14, 0);
		chk(serr, 1'b1);
		chk(rdat, 32'h0);
		// One missing condition at a time keeps the request off
		for (i = 0; i < 3; i++)
		begin
			mute_field_i.put(i == 0, (i == 1) ? 4'h0 : 4'h3, i == 2);
			repeat (3) @(posedge pclk);
			chk(ctl.override_req, 1'b0);
		end
		// Request while masked, then unmask and clear
		apb(1'b1, MASK_OFF, 0);
		mute_field_i.put(1'b0, 4'h3, 1'b0);
		repeat (3) @(posedge pclk);
		chk(ctl.override_req, 1'b1);
		chk(irq, 1'b0);
		apb(1'b0, CNT_OFF, 0);
		chk(rdat, 32'h1);
		apb(1'b1, MASK_OFF, 32'h1);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b1);
		apb(1'b1, IRQ_OFF, 32'h1);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b0);
		// Pulse far below the minimum width is ignored
		mute_field_i.press(50);
		repeat (3) @(posedge pclk);
		chk(ctl.release_out, 1'b0);
		// Long minimum: 200 ms too short, then 3.1 s too long
		apb(1'b1, CTRL_OFF, 32'h1);
		mute_field_i.press(200 * MS);
		repeat (3) @(posedge pclk);
		chk(ctl.release_out, 1'b0);
		mute_field_i.press(3100 * MS);
		repeat (3) @(posedge pclk);
		chk(ctl.release_out, 1'b0);
		// Valid 150 ms pulse under the short minimum starts override
		apb(1'b1, CTRL_OFF, 32'h0);
		mute_field_i.press(150 * MS);
		repeat (3) @(posedge pclk);
		chk(ctl.release_out, 1'b1);
		chk(ctl.override_active, 1'b1);
		chk(ctl.checks_suspend, 1'b1);
		chk(ctl.override_req, 1'b0);
		apb(1'b0, STAT_OFF, 0);
		chk(rdat, 32'h14);
		apb(1'b0, IRQ_OFF, 0);
		chk(rdat, 32'h2);
		// Clear field ends the override cycle
		mute_field_i.put(1'b0, 4'h0, 1'b1);
		repeat (3) @(posedge pclk);
		chk(ctl.release_out, 1'b0);
		chk(ctl.override_active, 1'b0);
		// Request blinks at 2 Hz; a fault abort forces one high cycle
		mute_field_i.put(1'b0, 4'h3, 1'b0);
		repeat (3) @(posedge pclk);
		chk(ctl.override_req, 1'b1);
		repeat (255 * MS) @(posedge pclk);
		chk(ctl.override_req, 1'b0);
		mute_field_i.fault();
		@(posedge pclk);
		chk(ctl.override_req, 1'b1);
		@(posedge pclk);
		chk(ctl.override_req, 1'b0);
		repeat (250 * MS) @(posedge pclk);
		chk(ctl.override_req, 1'b1);
		// Fault with field clear: no request, held until rearmed
		mute_field_i.put(1'b0, 4'h0, 1'b1);
		mute_field_i.fault();
		repeat (3) @(posedge pclk);
		chk(ctl.override_req, 1'b0);
		mute_field_i.put(1'b0, 4'h3, 1'b0);
		repeat (3) @(posedge pclk);
		chk(ctl.override_req, 1'b0);
		mute_field_i.put(1'b0, 4'h0, 1'b0);
		mute_field_i.put(1'b0, 4'h3, 1'b0);
		repeat (3) @(posedge pclk);
		chk(ctl.override_req, 1'b1);
		// Count limit for every time setting, last one unmonitored
		for (i = 0; i < 10; i++)
		begin
			apb(1'b1, CTRL_OFF, {24'h0, (i < 9) ? i[3:0] : 4'h0,
				2'b00, i < 9, 1'b0});
			mute_field_i.put(1'b0, 4'h0, 1'b1);
			mute_field_i.restart();
			mute_field_i.mute_done();
			for (j = 0; j <= lim[i]; j++)
			begin
				mute_field_i.put(1'b0, 4'h3, 1'b0);
				repeat (3) @(posedge pclk);
				chk(ctl.override_req, j < lim[i]);
				mute_field_i.put(1'b0, 4'h0, 1'b1);
				repeat (3) @(posedge pclk);
			end
			apb(1'b0, CNT_OFF, 0);
			chk(rdat, lim[i]);
		end
		apb(1'b0, IRQ_OFF, 0);
		chk(rdat, 32'h7);
		// Without a restart a muting cycle keeps the count
		mute_field_i.mute_done();
		apb(1'b0, CNT_OFF, 0);
		chk(rdat, 32'h5);
		mute_field_i.restart();
		mute_field_i.mute_done();
		apb(1'b0, CNT_OFF, 0);
		chk(rdat, 32'h0);
		results();
	end
endmodule : testbench
